// >>> inc/ied_pkg.sv
// integer execute decode: shared encodings, masks, types and counts
// assumes one core clock with a synchronous active-low reset
package ied_pkg;
  // primary opcodes
  localparam logic [5:0] OP_SPECIAL  = 6'h00;
  localparam logic [5:0] OP_JUMP     = 6'h02;
  localparam logic [5:0] OP_LINKJUMP = 6'h03;
  localparam logic [5:0] OP_SPECIAL2 = 6'h1c;
  localparam logic [2:0] ROW_BRANCH  = 3'h0;
  localparam logic [2:0] ROW_IMM     = 3'h1;
  localparam logic [2:0] ROW_LIKELY  = 3'h2;
  // special function fields
  localparam logic [5:0] FN_REGJUMP  = 6'h08;
  localparam logic [5:0] FN_REGLINK  = 6'h09;
  localparam logic [5:0] FN_TRAP_LO  = 6'h30;
  localparam logic [5:0] FN_TRAP_HI  = 6'h36;
  localparam logic [3:0] FN_HILO_ROW = 4'h4;
  localparam logic [3:0] FN_MDIV_ROW = 4'h6;
  // special2 function fields
  localparam logic [5:0] FN_SACC     = 6'h00;
  localparam logic [5:0] FN_UACC     = 6'h01;
  localparam logic [5:0] FN_MUL      = 6'h02;
  localparam logic [5:0] FN_SSUB     = 6'h04;
  localparam logic [5:0] FN_USUB     = 6'h05;
  localparam logic [5:0] FN_LZEROS   = 6'h20;
  localparam logic [5:0] FN_LONES    = 6'h21;
  localparam logic [5:0] FN_DBREAK   = 6'h3f;
  // one bit per encoding: reserved and absent-coprocessor entries
  localparam logic [63:0] PRI_RSVD_MASK = 64'h9890_3080_ef00_0000;
  localparam logic [63:0] PRI_COPU_MASK = 64'h6666_0000_000e_0000;
  localparam logic [63:0] SPC_RSVD_MASK = 64'hffa0_f300_f0f0_4020;
  localparam logic [63:0] SPC_COPU_MASK = 64'h0000_0000_0000_0002;
  // misc values
  localparam logic [31:0] NOP_WORD      = 32'h0000_0000;
  localparam logic [31:0] NOP_INHIBIT   = 32'h0000_0040;
  localparam logic [31:0] INSTR_BYTES   = 32'h0000_0004;
  localparam logic [31:0] LINK_OFFSET   = 32'h0000_0008;
  localparam logic [4:0]  LINK_REG      = 5'h1f;
  localparam logic [5:0]  WORD_BITS     = 6'h20;
  localparam int          MUL_LATENCY   = 4;

  // instruction class handed to the execute pipeline
  typedef enum logic [3:0] {
    CLS_NOP     = 4'b0000,
    CLS_ALU_REG = 4'b0001,
    CLS_ALU_IMM = 4'b0010,
    CLS_JUMP    = 4'b0011,
    CLS_BRANCH  = 4'b0100,
    CLS_TRAP    = 4'b0101,
    CLS_MULDIV  = 4'b0110,
    CLS_HILO    = 4'b0111,
    CLS_COUNT   = 4'b1000,
    CLS_OTHER   = 4'b1001,
    CLS_FAULT   = 4'b1010
  } ied_class_type;

  // multiplier operation
  typedef enum logic [1:0] {
    MK_PROD = 2'b00,
    MK_ACC  = 2'b01,
    MK_SUB  = 2'b10,
    MK_DIV  = 2'b11
  } ied_mul_kind_type;

  // delay slot tracking
  typedef enum logic [1:0] {
    SLOT_IDLE = 2'b00,
    SLOT_RUN  = 2'b01,
    SLOT_NULL = 2'b10
  } ied_slot_type;

  typedef struct packed {
    logic             start;
    ied_mul_kind_type kind;
    logic             sgn;
    logic [31:0]      a;
    logic [31:0]      b;
  } ied_mul_req_type;

  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [31:0] data;
  } ied_wb_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] target;
  } ied_redirect_type;
endpackage

// >>> core/ied_mul_unit.sv
// integer execute decode: separate multiplier with the high/low pair
// assumes requests only arrive while busy_out is low
`timescale 1ns/1ns
`default_nettype none
module ied_mul_unit #(
  parameter int LATENCY = ied_pkg::MUL_LATENCY
) (
  input  wire logic                     clock_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     enable_in,
  input  wire ied_pkg::ied_mul_req_type req_in,
  input  wire logic                     write_hi_in,
  input  wire logic                     write_lo_in,
  input  wire logic [31:0]              write_data_in,
  output logic                          busy_out,
  output logic [31:0]                   hi_out,
  output logic [31:0]                   lo_out
);
  ied_pkg::ied_mul_req_type op;    // latched operation
  logic [63:0]              base;  // pair value at start
  logic [7:0]               cnt;   // cycles left
  logic [63:0]              ea;    // extended operands
  logic [63:0]              eb;
  logic [63:0]              prod;
  logic [63:0]              next_pair;

  // 64-bit product and the value written back
  always_comb begin
    ea   = op.sgn ? {{32{op.a[31]}}, op.a} : {32'h0000_0000, op.a};
    eb   = op.sgn ? {{32{op.b[31]}}, op.b} : {32'h0000_0000, op.b};
    prod = ea * eb;
    case (op.kind)
      ied_pkg::MK_ACC: next_pair = base + prod;
      ied_pkg::MK_SUB: next_pair = base - prod;
      ied_pkg::MK_DIV: begin
        // zero divisor leaves an arbitrary but defined zero
        if (op.b == 32'h0000_0000) next_pair = 64'h0000_0000_0000_0000;
        else if (op.sgn) next_pair = {32'($signed(op.a) % $signed(op.b)),
                                      32'($signed(op.a) / $signed(op.b))};
        else next_pair = {op.a % op.b, op.a / op.b};
      end
      default: next_pair = prod;
    endcase
  end

  // operation latch and countdown
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cnt  <= 8'h00;
      op   <= '0;
      base <= 64'h0000_0000_0000_0000;
    end else if (enable_in) begin
      if (req_in.start && cnt == 8'h00) begin
        cnt  <= 8'(LATENCY);
        op   <= req_in;
        base <= {hi_out, lo_out};
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // high/low pair: result on the last cycle, direct writes only while idle
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      hi_out <= 32'h0000_0000;
      lo_out <= 32'h0000_0000;
    end else if (enable_in) begin
      if (cnt == 8'h01) begin
        hi_out <= next_pair[63:32];
        lo_out <= next_pair[31:0];
      end else if (cnt == 8'h00) begin
        if (write_hi_in) hi_out <= write_data_in;
        if (write_lo_in) lo_out <= write_data_in;
      end
    end
  end

  assign busy_out = (cnt != 8'h00);

  // accumulate and subtract results checked as differences
  a_acc_result: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (enable_in && cnt == 8'h01 && op.kind == ied_pkg::MK_ACC)
    |=> ({hi_out, lo_out} - base) == ($past(ea) * $past(eb)))
    else $error("accumulate result wrong");
  a_sub_result: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (enable_in && cnt == 8'h01 && op.kind == ied_pkg::MK_SUB)
    |=> (base - {hi_out, lo_out}) == ($past(ea) * $past(eb)))
    else $error("subtract result wrong");
endmodule
`default_nettype wire

// >>> core/ied_core.sv
// integer execute decode: decode, control transfer and simple execute
// assumes fetch holds instr_valid_in and operands while stall_out is high
`timescale 1ns/1ns
`default_nettype none
module ied_core #(
  parameter int MUL_LATENCY = ied_pkg::MUL_LATENCY
) (
  input  wire logic                   clock_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   enable_in,
  input  wire logic                   instr_valid_in,
  input  wire logic [31:0]            instr_in,
  input  wire logic [31:0]            pc_in,
  input  wire logic [31:0]            a_value_in,
  input  wire logic [31:0]            b_value_in,
  output logic                        stall_out,
  output ied_pkg::ied_wb_type         wb_out,
  output ied_pkg::ied_redirect_type   redirect_out,
  output ied_pkg::ied_class_type      class_out,
  output logic                        r_format_out,
  output logic                        nullified_out,
  output logic                        rsvd_fault_out,
  output logic                        cop_fault_out
);
  // instruction fields
  logic [5:0]             opcode;
  logic [5:0]             func;
  logic [4:0]             rd_f;
  logic [15:0]            imm;
  // decode results
  ied_pkg::ied_class_type cls;
  logic                   r_fmt;
  logic                   rsvd;
  logic                   copu;
  logic                   is_br;
  logic                   likely;
  logic                   taken;
  logic                   jump;
  logic [31:0]            target;
  logic                   link;
  logic [4:0]             link_idx;
  logic                   count_en;
  logic                   count_ones;
  logic                   mul_reg;
  logic                   rd_hi;
  logic                   rd_lo;
  logic                   wr_hi;
  logic                   wr_lo;
  ied_pkg::ied_mul_req_type mreq;
  // control
  ied_pkg::ied_slot_type  slot;
  logic                   accept;
  logic                   active;
  logic                   mul_busy;
  logic [31:0]            hi_val;
  logic [31:0]            lo_val;
  logic [31:0]            next_data;
  logic [63:0]            chk_prod; // check only

  // leading zero count, 32 for an all-zero word
  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic [5:0] n;
    logic       hit;
    n   = ied_pkg::WORD_BITS;
    hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!hit && v[i]) begin
        n   = 6'(31 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  assign opcode = instr_in[31:26];
  assign func   = instr_in[5:0];
  assign rd_f   = instr_in[15:11];
  assign imm    = instr_in[15:0];

  // main decode
  always_comb begin
    cls        = ied_pkg::CLS_OTHER;
    r_fmt      = 1'b0;
    rsvd       = 1'b0;
    copu       = 1'b0;
    is_br      = 1'b0;
    likely     = 1'b0;
    taken      = 1'b0;
    jump       = 1'b0;
    target     = 32'h0000_0000;
    link       = 1'b0;
    link_idx   = rd_f;
    count_en   = 1'b0;
    count_ones = 1'b0;
    mul_reg    = 1'b0;
    rd_hi      = 1'b0;
    rd_lo      = 1'b0;
    wr_hi      = 1'b0;
    wr_lo      = 1'b0;
    mreq       = '0;
    mreq.a     = a_value_in;
    mreq.b     = b_value_in;
    mreq.sgn   = 1'b1;
    if (opcode == ied_pkg::OP_SPECIAL) begin
      // special submap, function row and column
      r_fmt = 1'b1;
      cls   = ied_pkg::CLS_ALU_REG;
      rsvd  = ied_pkg::SPC_RSVD_MASK[func];
      copu  = ied_pkg::SPC_COPU_MASK[func];
      if (instr_in == ied_pkg::NOP_WORD || instr_in == ied_pkg::NOP_INHIBIT) begin
        cls = ied_pkg::CLS_NOP;
      end else if (func == ied_pkg::FN_REGJUMP || func == ied_pkg::FN_REGLINK) begin
        cls    = ied_pkg::CLS_JUMP;
        jump   = 1'b1;
        target = a_value_in;
        link   = (func == ied_pkg::FN_REGLINK);
      end else if (func >= ied_pkg::FN_TRAP_LO && func <= ied_pkg::FN_TRAP_HI) begin
        cls = ied_pkg::CLS_TRAP;
      end else if (func[5:2] == ied_pkg::FN_HILO_ROW) begin
        cls   = ied_pkg::CLS_HILO;
        rd_hi = !func[1] && !func[0];
        wr_hi = !func[1] && func[0];
        rd_lo = func[1] && !func[0];
        wr_lo = func[1] && func[0];
      end else if (func[5:2] == ied_pkg::FN_MDIV_ROW) begin
        cls        = ied_pkg::CLS_MULDIV;
        mreq.start = 1'b1;
        mreq.kind  = func[1] ? ied_pkg::MK_DIV : ied_pkg::MK_PROD;
        mreq.sgn   = !func[0];
      end
    end else if (opcode == ied_pkg::OP_SPECIAL2) begin
      // special2 submap; unlisted entries are reserved
      r_fmt = 1'b1;
      case (func)
        ied_pkg::FN_SACC, ied_pkg::FN_UACC,
        ied_pkg::FN_SSUB, ied_pkg::FN_USUB: begin
          cls        = ied_pkg::CLS_MULDIV;
          mreq.start = 1'b1;
          mreq.kind  = func[2] ? ied_pkg::MK_SUB : ied_pkg::MK_ACC;
          mreq.sgn   = !func[0];
        end
        ied_pkg::FN_MUL: begin
          cls     = ied_pkg::CLS_ALU_REG;
          mul_reg = 1'b1;
        end
        ied_pkg::FN_LZEROS, ied_pkg::FN_LONES: begin
          cls        = ied_pkg::CLS_COUNT;
          count_en   = 1'b1;
          count_ones = func[0];
        end
        ied_pkg::FN_DBREAK: cls = ied_pkg::CLS_OTHER;
        default: rsvd = 1'b1;
      endcase
    end else begin
      // primary map, opcode row and column
      rsvd = ied_pkg::PRI_RSVD_MASK[opcode];
      copu = ied_pkg::PRI_COPU_MASK[opcode];
      if (opcode[5:3] == ied_pkg::ROW_IMM) begin
        cls = ied_pkg::CLS_ALU_IMM;
      end else if (opcode == ied_pkg::OP_JUMP || opcode == ied_pkg::OP_LINKJUMP) begin
        cls      = ied_pkg::CLS_JUMP;
        jump     = 1'b1;
        target   = {pc_in[31:28], instr_in[25:0], 2'b00};
        link     = opcode[0];
        link_idx = ied_pkg::LINK_REG;
      end else if ((opcode[5:3] == ied_pkg::ROW_BRANCH || opcode[5:3] == ied_pkg::ROW_LIKELY)
                   && opcode[2]) begin
        cls    = ied_pkg::CLS_BRANCH;
        is_br  = 1'b1;
        likely = (opcode[5:3] == ied_pkg::ROW_LIKELY);
        target = pc_in + ied_pkg::INSTR_BYTES + {{14{imm[15]}}, imm, 2'b00};
        case (opcode[1:0])
          2'b00:   taken = (a_value_in == b_value_in);
          2'b01:   taken = (a_value_in != b_value_in);
          2'b10:   taken = a_value_in[31] || (a_value_in == 32'h0000_0000);
          default: taken = !a_value_in[31] && (a_value_in != 32'h0000_0000);
        endcase
      end
    end
    if (rsvd || copu) begin
      cls = ied_pkg::CLS_FAULT;
    end
  end

  // hold multiply and high/low move instructions while the multiplier owns the pair
  assign stall_out = instr_valid_in && mul_busy
                     && (mreq.start || rd_hi || rd_lo || wr_hi || wr_lo);
  assign accept    = enable_in && instr_valid_in && !stall_out;
  assign active    = accept && (slot != ied_pkg::SLOT_NULL);

  // delay slot state after each jump or branch
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      slot <= ied_pkg::SLOT_IDLE;
    end else if (accept) begin
      if (active && (jump || is_br)) begin
        slot <= (likely && !taken) ? ied_pkg::SLOT_NULL : ied_pkg::SLOT_RUN;
      end else begin
        slot <= ied_pkg::SLOT_IDLE;
      end
    end
  end

  // redirect fetch; the slot instruction still executes
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      redirect_out <= '0;
    end else if (enable_in) begin
      redirect_out.valid <= active && (jump || (is_br && taken));
      if (active) redirect_out.target <= target;
    end
  end

  // register write data selection
  always_comb begin
    next_data = hi_val;
    if (link) next_data = pc_in + ied_pkg::LINK_OFFSET;
    else if (count_en) next_data = {26'h000_0000,
        lead_zeros(count_ones ? ~a_value_in : a_value_in)};
    else if (mul_reg) next_data = 32'(a_value_in * b_value_in);
    else if (rd_lo) next_data = lo_val;
  end

  // register write port
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      wb_out <= '0;
    end else if (enable_in) begin
      wb_out.en <= active && !rsvd && !copu
                   && (link || count_en || mul_reg || rd_hi || rd_lo);
      if (active) begin
        wb_out.idx  <= link ? link_idx : rd_f;
        wb_out.data <= next_data;
      end
    end
  end

  // class, format, nullify and fault flags
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      class_out      <= ied_pkg::CLS_NOP;
      r_format_out   <= 1'b0;
      nullified_out  <= 1'b0;
      rsvd_fault_out <= 1'b0;
      cop_fault_out  <= 1'b0;
    end else if (enable_in) begin
      class_out      <= active ? cls : ied_pkg::CLS_NOP;
      r_format_out   <= active && r_fmt;
      nullified_out  <= accept && !active;
      rsvd_fault_out <= active && rsvd;
      cop_fault_out  <= active && copu && !rsvd;
    end
  end

  ied_mul_unit #(
    .LATENCY(MUL_LATENCY)
  ) u_mul (
    .clock_in     (clock_in),
    .rst_b_in     (rst_b_in),
    .enable_in    (enable_in),
    .req_in       ({mreq.start && active && !rsvd, mreq.kind, mreq.sgn,
                    mreq.a, mreq.b}),
    .write_hi_in  (active && wr_hi),
    .write_lo_in  (active && wr_lo),
    .write_data_in(a_value_in),
    .busy_out     (mul_busy),
    .hi_out       (hi_val),
    .lo_out       (lo_val)
  );

  // checks
  assign chk_prod = {{32{a_value_in[31]}}, a_value_in} * {{32{b_value_in[31]}}, b_value_in};

  default clocking dcb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  sequence likely_miss;
    active && is_br && likely && !taken;
  endsequence
  sequence slot_taken_null;
    accept && slot == ied_pkg::SLOT_NULL;
  endsequence

  a_jump_target: assert property (
    active && opcode == ied_pkg::OP_JUMP |=> redirect_out.valid
    && redirect_out.target == {$past(pc_in[31:28]), $past(instr_in[25:0]), 2'b00})
    else $error("jump target wrong");
  a_reg_jump: assert property (
    active && jump && r_fmt
    |=> redirect_out.valid && redirect_out.target == $past(a_value_in))
    else $error("register jump target wrong");
  a_branch_target: assert property (
    active && is_br && taken |=> redirect_out.valid && (redirect_out.target
    - $past(pc_in) - 32'h0000_0004) == {{14{$past(imm[15])}}, $past(imm), 2'b00})
    else $error("branch target wrong");
  a_likely_null: assert property (
    likely_miss ##1 slot_taken_null |=> nullified_out && !wb_out.en
    && !redirect_out.valid && !rsvd_fault_out)
    else $error("likely slot not nullified");
  a_slot_runs: assert property (
    accept && slot == ied_pkg::SLOT_RUN |=> !nullified_out)
    else $error("delay slot dropped");
  a_hilo_stall: assert property (
    instr_valid_in && mul_busy && (rd_hi || rd_lo) |-> stall_out ##1 !wb_out.en)
    else $error("high/low read not stalled");
  a_count_zeros: assert property (
    active && count_en && !count_ones |=> wb_out.en && ((wb_out.data == 32'h0000_0020)
    ? $past(a_value_in) == 32'h0000_0000
    : ($past(a_value_in) >> (5'h1f - wb_out.data[4:0])) == 32'h0000_0001))
    else $error("leading zero count wrong");
  a_count_ones: assert property (
    active && count_ones |=> wb_out.en && ((wb_out.data == 32'h0000_0020)
    ? $past(a_value_in) == 32'hffff_ffff
    : (~$past(a_value_in) >> (5'h1f - wb_out.data[4:0])) == 32'h0000_0001))
    else $error("leading one count wrong");
  a_mul_low: assert property (
    active && mul_reg |=> wb_out.en && wb_out.data == $past(chk_prod[31:0]))
    else $error("multiply to register wrong");
  a_rsvd_fault: assert property (
    active && opcode[5:2] == 4'h6 |=> rsvd_fault_out && class_out == ied_pkg::CLS_FAULT)
    else $error("reserved opcode not faulted");
  a_cop_fault: assert property (
    active && opcode == 6'h11 |=> cop_fault_out && !wb_out.en)
    else $error("coprocessor encoding not faulted");
endmodule
`default_nettype wire

// >>> test/ied_regfile_model.sv
// register file model standing in for the fetch and write-back side
// assumes write-back pulses from the core last one cycle
`timescale 1ns/1ns
`default_nettype none
module ied_regfile_model (
  input  wire logic                clock_in,
  input  wire logic [31:0]         instr_in,
  input  wire ied_pkg::ied_wb_type wb_in,
  output logic [31:0]              a_value_out,
  output logic [31:0]              b_value_out
);
  logic [31:0] regs [32]; // general registers, zero reads as zero
  assign a_value_out = (instr_in[25:21] == 5'h00) ? 32'h0000_0000 : regs[instr_in[25:21]];
  assign b_value_out = (instr_in[20:16] == 5'h00) ? 32'h0000_0000 : regs[instr_in[20:16]];
  // commit each write-back pulse
  always @(posedge clock_in) begin
    if (wb_in.en === 1'b1) begin
      regs[wb_in.idx] <= wb_in.data;
    end
  end
endmodule
`default_nettype wire

// >>> test/ied_core_tb_top.sv
// bench for the decode core: one task per scenario, counts and verdict
// assumes the register file model supplies operands and takes writes
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
`define RG i_ied_regfile_model.regs
module ied_core_tb_top;
  logic clock_in, rst_b_in, enable, valid, stall, rf, nul, rsf, cpf, lrf;
  logic [31:0] instr, pc, rsv, rtv, tgt;
  ied_pkg::ied_wb_type wb;
  ied_pkg::ied_redirect_type rdr;
  ied_pkg::ied_class_type cls, lcls;
  int errors = 0;
  int check_count = 0;
  int cnt [7] = '{default: 0}; // redirect, rsvd, cop, null, wb, class, stall
  int s [7];                   // snapshot of the tallies
  ied_core i_ied_core (.clock_in(clock_in), .rst_b_in(rst_b_in), .enable_in(enable),
    .instr_valid_in(valid), .instr_in(instr), .pc_in(pc), .a_value_in(rsv),
    .b_value_in(rtv), .stall_out(stall), .wb_out(wb), .redirect_out(rdr),
    .class_out(cls), .r_format_out(rf), .nullified_out(nul), .rsvd_fault_out(rsf),
    .cop_fault_out(cpf));
  ied_regfile_model i_ied_regfile_model (.clock_in(clock_in), .instr_in(instr),
    .wb_in(wb), .a_value_out(rsv), .b_value_out(rtv));
  initial clock_in = 1'b0;
  always #50 clock_in = ~clock_in;
  // tally output pulses mid-cycle, once settled
  always @(negedge clock_in) begin
    if (rst_b_in === 1'b1) begin
      if (rdr.valid === 1'b1) begin
        cnt[0]++;
        tgt = rdr.target;
      end
      cnt[1] += int'(rsf === 1'b1);
      cnt[2] += int'(cpf === 1'b1);
      cnt[3] += int'(nul === 1'b1);
      cnt[4] += int'(wb.en === 1'b1);
      cnt[6] += int'(stall === 1'b1);
      if (cls !== ied_pkg::CLS_NOP) begin
        cnt[5]++;
        lcls = cls;
        lrf = rf;
      end
    end
  end
  function automatic logic [31:0] enc(input int op, a, b, d, f);
    return {6'(op), 5'(a), 5'(b), 5'(d), 5'h00, 6'(f)};
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // present at an edge, hold through stalls, return at the taking edge
  task automatic issue(input logic [31:0] w, input logic [31:0] a);
    int n = 0;
    valid <= 1'b1;
    instr <= w;
    pc <= a;
    #1;
    while (stall === 1'b1 && n < 50) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n == 50) begin
      errors++;
      final_report();
    end
    @(posedge clock_in);
  endtask
  // idle long enough for write-backs and the multiplier to settle
  task automatic flush();
    valid <= 1'b0;
    instr <= ied_pkg::NOP_WORD;
    repeat (8) @(posedge clock_in);
    #1;
  endtask
  task automatic t_reset();
    #1;
    `CHK("reset class", ied_pkg::CLS_NOP, cls)
    `CHK("reset outs", 4'h0, {stall, wb.en, rdr.valid, rsf})
    @(posedge clock_in);
    rst_b_in <= 1'b1;
  endtask
  task automatic t_jump();
    `RG[1] = 32'h0000_ffff;
    s = cnt;
    @(posedge clock_in);
    issue({ied_pkg::OP_JUMP, 26'h012_3456}, 32'ha000_1000);
    issue(enc(28, 1, 0, 3, 32), 32'ha000_1004);
    flush();
    `CHK("jump target", {4'ha, 26'h012_3456, 2'b00}, tgt)
    `CHK("jumps", 1, cnt[0] - s[0])
    `CHK("slot result", 32'h0000_0010, `RG[3])
    $display("test jump done");
  endtask
  task automatic t_count();
    logic [31:0] v [4] = '{32'hffff_ffff, 32'h8000_0000, 32'h0000_0000, 32'h0000_0001};
    int o [4] = '{32, 1, 0, 0};
    int z [4] = '{0, 0, 32, 31};
    for (int k = 0; k < 4; k++) begin
      `RG[1] = v[k];
      @(posedge clock_in);
      issue(enc(28, 1, 0, 4, 33), 0);
      issue(enc(28, 1, 0, 5, 32), 4);
      flush();
      `CHK("lead ones", o[k], `RG[4])
      `CHK("lead zeros", z[k], `RG[5])
    end
    $display("test count done");
  endtask
  task automatic t_ctl();
    `RG[1] = 32'h0000_0005;
    `RG[2] = 32'h1234_5678;
    `RG[7] = 32'h0000_0000;
    @(posedge clock_in);
    issue(enc(0, 2, 0, 5, 9), 32'h0000_0100);
    issue(ied_pkg::NOP_WORD, 32'h0000_0104);
    flush();
    `CHK("reg target", 32'h1234_5678, tgt)
    `CHK("link value", 32'h0000_0108, `RG[5])
    `CHK("reg format", 1'b1, lrf)
    @(posedge clock_in);
    issue({6'h04, 5'h01, 5'h01, 16'hfffe}, 32'h0000_2000);
    issue(ied_pkg::NOP_WORD, 32'h0000_2004);
    flush();
    `CHK("branch target", 32'h0000_2004 + {{14{1'b1}}, 16'hfffe, 2'b00}, tgt)
    s = cnt;
    @(posedge clock_in);
    issue({6'h14, 5'h01, 5'h02, 16'h0010}, 32'h0000_3000);
    issue(enc(28, 1, 0, 7, 32), 32'h0000_3004);
    flush();
    `CHK("nullified", 1, cnt[3] - s[3])
    `CHK("slot no write", 32'h0000_0000, `RG[7])
    `CHK("not taken", 0, cnt[0] - s[0])
    $display("test control done");
  endtask
  task automatic t_mul();
    int f [4] = '{0, 1, 4, 5};
    logic [63:0] pu, ps, p, e;
    `RG[1] = 32'hffff_fffe;
    `RG[2] = 32'h0000_0003;
    `RG[3] = 32'h0000_0001;
    `RG[4] = 32'h0000_0000;
    pu = {32'h0000_0000, `RG[1]} * {32'h0000_0000, `RG[2]};
    ps = {{32{`RG[1][31]}}, `RG[1]} * {{32{`RG[2][31]}}, `RG[2]};
    for (int k = 0; k < 4; k++) begin
      s = cnt;
      p = k[0] ? pu : ps;
      e = k[1] ? 64'h0000_0001_0000_0000 - p : 64'h0000_0001_0000_0000 + p;
      @(posedge clock_in);
      issue(enc(0, 3, 0, 0, 17), 0);
      issue(enc(0, 4, 0, 0, 19), 4);
      issue(enc(28, 1, 2, 0, f[k]), 8);
      issue(enc(0, 0, 0, 8, 16), 12);
      issue(enc(0, 0, 0, 9, 18), 16);
      flush();
      `CHK("pair", e, {`RG[8], `RG[9]})
      `CHK("stalled", 1'b1, cnt[6] > s[6])
    end
    @(posedge clock_in);
    issue(enc(28, 1, 2, 10, 2), 20);
    flush();
    `CHK("low product", ps[31:0], `RG[10])
    $display("test multiply done");
  endtask
  task automatic t_decode();
    logic [31:0] w [7] = '{32'h6000_0000, 32'h4400_0000, 32'h0000_0005, 32'h0000_0001,
                           32'h2022_0005, 32'h0022_1820, 32'h0022_0034};
    logic [1:0] fl [7] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
    ied_pkg::ied_class_type cl [3] = '{ied_pkg::CLS_ALU_IMM, ied_pkg::CLS_ALU_REG,
                                       ied_pkg::CLS_TRAP};
    logic r [3] = '{1'b0, 1'b1, 1'b1};
    for (int k = 0; k < 7; k++) begin
      s = cnt;
      @(posedge clock_in);
      issue(w[k], 32'h0000_4000);
      flush();
      `CHK("reserved", int'(fl[k][0]), cnt[1] - s[1])
      `CHK("unusable", int'(fl[k][1]), cnt[2] - s[2])
      if (k > 3) begin
        `CHK("class", cl[k - 4], lcls)
        `CHK("format", r[k - 4], lrf)
      end
    end
    s = cnt;
    @(posedge clock_in);
    issue(ied_pkg::NOP_INHIBIT, 32'h0000_4004);
    flush();
    `CHK("noop effect", 0, cnt[5] - s[5] + cnt[4] - s[4] + cnt[1] - s[1])
    $display("test decode done");
  endtask
  // clock enable low freezes the redirect pulse and all state
  task automatic t_freeze();
    s = cnt;
    @(posedge clock_in);
    issue({ied_pkg::OP_JUMP, 26'h000_0010}, 32'h0000_5000);
    enable <= 1'b0;
    repeat (3) @(posedge clock_in);
    enable <= 1'b1;
    flush();
    `CHK("frozen pulse", 4, cnt[0] - s[0])
    `CHK("frozen target", 32'h0000_0040, tgt)
    $display("test freeze done");
  endtask
  // reset for ten cycles, then the scenarios in turn
  initial begin
    rst_b_in = 1'b0;
    enable = 1'b1;
    valid = 1'b0;
    instr = 32'h0000_0000;
    pc = 32'h0000_0000;
    repeat (9) @(posedge clock_in);
    t_reset();
    t_jump();
    t_count();
    t_ctl();
    t_mul();
    t_decode();
    t_freeze();
    final_report();
  end
endmodule
`default_nettype wire
